// file: logic/dssp_pkg.sv
// shared constants and types of the dual supply stimulus and protection block
package dssp_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int REF_HZ = 1_000_000;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int SAMPLE_DIV_MAX = REF_HZ;
  localparam int SAMPLE_DIV_W = 20;
  localparam int STIM_DEPTH = 8192;
  localparam int STIM_AW = 13;
  localparam int CODE_W = 16;

  // voltage code steps in microvolts
  localparam int VSET_STEP_UV = 371;
  localparam int VSET_RANGE_UV = 12_000_000;
  localparam int RAIL_SWITCH_UV = 5_500_000;
  localparam int VSET_MAX_CODE = VSET_RANGE_UV / VSET_STEP_UV;
  localparam int RAIL_HIGH_CODE = (RAIL_SWITCH_UV + VSET_STEP_UV - 1) / VSET_STEP_UV;

  // current limit steps in microamps
  localparam int ILIM_W = 10;
  localparam int ILIM_STEP_UA = 220;
  localparam int ILIM_MIN_UA = 10_000;
  localparam int ILIM_MAX_UA = 200_000;
  localparam int ILIM_MIN_CODE = (ILIM_MIN_UA + ILIM_STEP_UA - 1) / ILIM_STEP_UA;
  localparam int ILIM_MAX_CODE = ILIM_MAX_UA / ILIM_STEP_UA;

  // monitor scale, for software use
  localparam int MON_V_STEP_UV = 372;
  localparam int MON_I_STEP_NA = 7_600;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_CLKDIV = 8'h08;
  localparam logic [7:0] OFS_CH_BASE = 8'h10;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [3:0] OFS_VSET = 4'h0;
  localparam logic [3:0] OFS_ILIM = 4'h4;
  localparam logic [3:0] OFS_CONN = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [7:0] OFS_MEMADDR = 8'h30;
  localparam logic [7:0] OFS_MEMDATA0 = 8'h34;
  localparam logic [7:0] OFS_MEMDATA1 = 8'h38;
  localparam logic [7:0] OFS_STIMSTART = 8'h40;
  localparam logic [7:0] OFS_STIMLAST = 8'h44;
  localparam logic [7:0] OFS_MON0 = 8'h48;
  localparam logic [7:0] OFS_MON1 = 8'h4C;

  localparam int CTRL_MEAS = 0;
  localparam int CTRL_SELFTEST = 1;
  localparam int CTRL_AUTOCAL = 2;
  localparam int CTRL_STERR = 3;
  localparam int CONN_RELAY = 0;
  localparam int CONN_FOURWIRE = 1;
  localparam int CONN_CAL = 2;
  localparam int ST_CLIM = 0;
  localparam int ST_OTEMP = 1;
  localparam int ST_RELAY = 2;
  localparam int ST_PLAY = 3;
  localparam logic [SAMPLE_DIV_W-1:0] CLKDIV_RESET = 20'h0_0001;

  typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_RED} dssp_led_t;

  typedef struct packed {
    logic [CODE_W-1:0] vset;
    logic [ILIM_W-1:0] ilim;
    logic relayClose;
    logic fourWire;
    logic chanCal;
  } dssp_chan_cfg_t;
endpackage

// file: logic/dssp_sample_div.sv
// 1 MHz reference and programmable sample clock enable
`timescale 1ns/1ps
`default_nettype none
module dssp_sample_div #(
  parameter int PRESCALE = dssp_pkg::REF_DIV,
  parameter int DW = dssp_pkg::SAMPLE_DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [DW-1:0] divider,
  output logic sampleEn
);
  if (PRESCALE < 1 || PRESCALE > 65536 || DW < 1) begin : g_chk
    $error("dssp_sample_div: bad parameters");
  end

  logic [15:0] preCnt_reg;
  logic [DW-1:0] divCnt_reg;
  wire refTick = (preCnt_reg == 16'(PRESCALE - 1));
  // a zero divider is served as one
  wire [DW-1:0] divEff = (divider == '0) ? DW'(1) : divider;
  wire divWrap = refTick && (divCnt_reg >= divEff - DW'(1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_reg <= 16'h0000;
      divCnt_reg <= '0;
      sampleEn <= 1'b0;
    end else begin
      preCnt_reg <= refTick ? 16'h0000 : preCnt_reg + 16'h0001;
      if (refTick) begin
        divCnt_reg <= divWrap ? '0 : divCnt_reg + DW'(1);
      end
      sampleEn <= divWrap; // [RULE3] [RULE19]
    end
  end
endmodule // dssp_sample_div
`default_nettype wire

// file: logic/dssp_stim_chan.sv
// one channel's stimulus memory and looping address counter
`timescale 1ns/1ps
`default_nettype none
module dssp_stim_chan #(
  parameter int DEPTH = dssp_pkg::STIM_DEPTH,
  parameter int AW = dssp_pkg::STIM_AW,
  parameter int DW = dssp_pkg::CODE_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic memWr,
  input wire logic [AW-1:0] memAddr,
  input wire logic [DW-1:0] memData,
  input wire logic load,
  input wire logic run,
  input wire logic sampleEn,
  input wire logic [AW-1:0] startAddr,
  input wire logic [AW-1:0] lastAddr,
  output logic [DW-1:0] sample
);
  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
    $error("dssp_stim_chan: depth does not fit address width");
  end

  logic [DW-1:0] mem [DEPTH]; // [RULE1]
  logic [AW-1:0] addr_reg;
  wire atLast = (addr_reg == lastAddr);
  // read ahead on load, so the first played word is never a stale one
  wire [AW-1:0] rdAddr = load ? startAddr : addr_reg;

  always_ff @(posedge clk_sys) begin
    if (memWr) begin
      mem[memAddr] <= memData; // [RULE1]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= '0;
      sample <= '0;
    end else begin
      if (load) begin
        addr_reg <= startAddr; // [RULE17]
      end else if (run && sampleEn) begin
        addr_reg <= atLast ? startAddr : addr_reg + AW'(1); // [RULE17] [RULE18]
      end
      sample <= mem[rdAddr];
    end
  end
endmodule // dssp_stim_chan
`default_nettype wire

// file: logic/dssp_top.sv
// dual supply module control: registers, stimulus playback, protection, leds
// How it works
// RULE1 - each channel owns an 8k-sample stimulus memory
// RULE2 - stimulus only runs in measurement mode
// RULE3 - sample clock divided from 1 MHz reference
// RULE4 - playback starts on mode plus channel trigger
// RULE5 - voltage code spans +/-12 V, 371 uV steps
// RULE6 - 15 V rail from 5.5 V upward; railHigh follows vset only, not played stimulus words
// RULE7 - current limit 10-200 mA, resets to 200
// RULE8 - current limit turns gate led red
// RULE9 - overtemperature opens all relays, driver off
// RULE10 - stays off until cool and status reset
// RULE11 - status register shows limit and overtemperature
// RULE12 - host clears hung limiter by set sequence
// RULE13 - 16-bit voltage and current monitor readings
// RULE14 - main led off, green, or red
// RULE15 - gate led off, green, or red
// RULE16 - two-wire mode ties sense to force
// RULE17 - address counter loads start, steps per sample
// RULE18 - counter reloads start after last sample
// RULE19 - one sample enable per N reference cycles
// RULE20 - status flags stick until host reset
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dssp_top #(
  parameter int NCH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [dssp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic thermalShutdownPin,
  input wire logic [NCH-1:0] currentLimitPin,
  input wire logic [NCH*16-1:0] monVoltPin,
  input wire logic [NCH*16-1:0] monCurPin,
  output logic [NCH*16-1:0] dacCode,
  output logic [NCH-1:0] railHigh,
  output logic [NCH*10-1:0] ilimCode,
  output logic [NCH-1:0] relayClosed,
  output logic [NCH-1:0] senseInternal,
  output logic driverEnable,
  output dssp_pkg::dssp_led_t mainLed,
  output dssp_pkg::dssp_led_t [NCH-1:0] gateLed
);
  if (NCH != 2) begin : g_chk
    $error("dssp_top: register map serves exactly two channels");
  end

  localparam int AW = dssp_pkg::STIM_AW;
  localparam int CW = dssp_pkg::CODE_W;
  localparam int IW = dssp_pkg::ILIM_W;
  localparam int DVW = dssp_pkg::SAMPLE_DIV_W;

  // ---------------- pin synchronisers ----------------
  logic otMeta_reg;
  logic otSync_reg;
  logic [NCH-1:0] clMeta_reg;
  logic [NCH-1:0] clSync_reg;
  logic [NCH*16-1:0] mvMeta_reg;
  logic [NCH*16-1:0] mvSync_reg;
  logic [NCH*16-1:0] miMeta_reg;
  logic [NCH*16-1:0] miSync_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otMeta_reg <= 1'b0;
      otSync_reg <= 1'b0;
      clMeta_reg <= '0;
      clSync_reg <= '0;
      mvMeta_reg <= '0;
      mvSync_reg <= '0;
      miMeta_reg <= '0;
      miSync_reg <= '0;
    end else begin
      otMeta_reg <= thermalShutdownPin;
      otSync_reg <= otMeta_reg;
      clMeta_reg <= currentLimitPin;
      clSync_reg <= clMeta_reg;
      mvMeta_reg <= monVoltPin;
      mvSync_reg <= mvMeta_reg;
      miMeta_reg <= monCurPin;
      miSync_reg <= miMeta_reg;
    end
  end

  // ---------------- register decode ----------------
  logic [3:0] ctrl_reg;
  logic [DVW-1:0] clkDiv_reg;
  logic [AW-1:0] memAddr_reg;
  logic [NCH*16-1:0] stimStart_reg;
  logic [NCH*16-1:0] stimLast_reg;
  dssp_pkg::dssp_chan_cfg_t [NCH-1:0] cfg_reg;
  logic [NCH-1:0] clFlag_reg;
  logic [NCH-1:0] otFlag_reg;
  logic [NCH-1:0] play_reg;
  logic [NCH*16-1:0] monV_reg;
  logic [NCH*16-1:0] monI_reg;
  logic [NCH*16-1:0] monVoltPrev;
  logic [NCH*16-1:0] monCurPrev;

  wire measMode = ctrl_reg[dssp_pkg::CTRL_MEAS];
  wire wrCtrl = regWr && (regAddr == dssp_pkg::OFS_CTRL);
  wire wrTrig = regWr && (regAddr == dssp_pkg::OFS_TRIG);
  wire wrDiv = regWr && (regAddr == dssp_pkg::OFS_CLKDIV);
  wire wrMemAddr = regWr && (regAddr == dssp_pkg::OFS_MEMADDR);
  wire wrStart = regWr && (regAddr == dssp_pkg::OFS_STIMSTART);
  wire wrLast = regWr && (regAddr == dssp_pkg::OFS_STIMLAST);
  wire [NCH-1:0] wrMem;
  assign wrMem[0] = regWr && (regAddr == dssp_pkg::OFS_MEMDATA0);
  assign wrMem[1] = regWr && (regAddr == dssp_pkg::OFS_MEMDATA1);
  wire anyMemWr = |wrMem;
  wire shutdown = |otFlag_reg; // [RULE10]
  wire sampleEn;

  // a zero divider is stored as one, the rate dssp_sample_div already serves zero at, so it reads back as one
  wire [DVW-1:0] divIn = regWdata[DVW-1:0];
  wire [DVW-1:0] divClamped = (divIn == '0) ? DVW'(1) :
    (divIn > DVW'(dssp_pkg::SAMPLE_DIV_MAX)) ? DVW'(dssp_pkg::SAMPLE_DIV_MAX) : divIn;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 4'h0;
      clkDiv_reg <= dssp_pkg::CLKDIV_RESET;
      memAddr_reg <= '0;
      stimStart_reg <= '0;
      stimLast_reg <= {NCH{16'(dssp_pkg::STIM_DEPTH - 1)}};
    end else begin
      if (wrCtrl) ctrl_reg <= regWdata[3:0];
      if (wrDiv) clkDiv_reg <= divClamped; // [RULE3]
      if (wrMemAddr) begin
        memAddr_reg <= regWdata[AW-1:0];
      end else if (anyMemWr) begin
        memAddr_reg <= memAddr_reg + AW'(1);
      end
      if (wrStart) stimStart_reg <= regWdata;
      if (wrLast) stimLast_reg <= regWdata;
    end
  end

  dssp_sample_div u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .divider(clkDiv_reg),
    .sampleEn(sampleEn)
  );

  // ---------------- per channel logic ----------------
  wire [NCH-1:0][31:0] chRead;
  wire [NCH-1:0] chHit;
  wire [NCH-1:0][CW-1:0] stimSample;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam logic [7:0] BASE = 8'(dssp_pkg::OFS_CH_BASE + c * dssp_pkg::OFS_CH_STRIDE);
    wire inCh = (regAddr[7:4] == BASE[7:4]);
    wire wrV = regWr && inCh && (regAddr[3:0] == dssp_pkg::OFS_VSET);
    wire wrI = regWr && inCh && (regAddr[3:0] == dssp_pkg::OFS_ILIM);
    wire wrC = regWr && inCh && (regAddr[3:0] == dssp_pkg::OFS_CONN);
    wire wrS = regWr && inCh && (regAddr[3:0] == dssp_pkg::OFS_STATUS);
    wire trig = wrTrig && regWdata[c];
    wire signed [CW-1:0] vIn = regWdata[CW-1:0];
    wire signed [CW-1:0] vMax = CW'(dssp_pkg::VSET_MAX_CODE);
    wire signed [CW-1:0] vClamp = (vIn > vMax) ? vMax : (vIn < -vMax) ? -vMax : vIn;
    wire [IW-1:0] iIn = regWdata[IW-1:0];
    wire [IW-1:0] iClamp = (iIn < IW'(dssp_pkg::ILIM_MIN_CODE)) ? IW'(dssp_pkg::ILIM_MIN_CODE) :
      (iIn > IW'(dssp_pkg::ILIM_MAX_CODE)) ? IW'(dssp_pkg::ILIM_MAX_CODE) : iIn;
    wire signed [CW-1:0] vProg = cfg_reg[c].vset;
    wire startPlay = trig && measMode && !shutdown; // [RULE4] [RULE2]
    // the hardware event wins over a host reset in the same cycle
    wire clClr = wrS && regWdata[dssp_pkg::ST_CLIM];
    wire otClr = wrS && regWdata[dssp_pkg::ST_OTEMP] && !otSync_reg; // [RULE10]
    wire [CW-1:0] outCode = play_reg[c] ? stimSample[c] : cfg_reg[c].vset;
    wire relayOn = cfg_reg[c].relayClose && !shutdown;

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cfg_reg[c] <= '{vset: '0, ilim: IW'(dssp_pkg::ILIM_MAX_CODE),
                        relayClose: 1'b0, fourWire: 1'b0, chanCal: 1'b0}; // [RULE7]
        clFlag_reg[c] <= 1'b0;
        otFlag_reg[c] <= 1'b0;
        play_reg[c] <= 1'b0;
      end else begin
        if (wrV) cfg_reg[c].vset <= vClamp; // [RULE5]
        if (wrI) cfg_reg[c].ilim <= iClamp; // [RULE7]
        if (wrC) begin
          cfg_reg[c].relayClose <= regWdata[dssp_pkg::CONN_RELAY];
          cfg_reg[c].fourWire <= regWdata[dssp_pkg::CONN_FOURWIRE];
          cfg_reg[c].chanCal <= regWdata[dssp_pkg::CONN_CAL];
        end
        if (clSync_reg[c]) clFlag_reg[c] <= 1'b1; // [RULE20]
        else if (clClr) clFlag_reg[c] <= 1'b0;
        if (otSync_reg) otFlag_reg[c] <= 1'b1; // [RULE20] [RULE9]
        else if (otClr) otFlag_reg[c] <= 1'b0;
        if (!measMode || shutdown) play_reg[c] <= 1'b0; // [RULE2]
        else if (startPlay) play_reg[c] <= 1'b1; // [RULE4]
      end
    end

    dssp_stim_chan u_stim (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .memWr(wrMem[c]),
      .memAddr(memAddr_reg),
      .memData(regWdata[CW-1:0]),
      .load(startPlay),
      .run(play_reg[c]),
      .sampleEn(sampleEn),
      .startAddr(stimStart_reg[c*16 +: AW]),
      .lastAddr(stimLast_reg[c*16 +: AW]),
      .sample(stimSample[c])
    );

    // monitor readings latch only when two synced samples agree, which
    // hides a word torn by the pin crossing
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        monV_reg[c*16 +: 16] <= 16'h0000;
        monI_reg[c*16 +: 16] <= 16'h0000;
      end else begin
        if (mvSync_reg[c*16 +: 16] == monVoltPrev[c*16 +: 16])
          monV_reg[c*16 +: 16] <= mvSync_reg[c*16 +: 16]; // [RULE13]
        if (miSync_reg[c*16 +: 16] == monCurPrev[c*16 +: 16])
          monI_reg[c*16 +: 16] <= miSync_reg[c*16 +: 16]; // [RULE13]
      end
    end

    // outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dacCode[c*16 +: 16] <= 16'h0000;
        railHigh[c] <= 1'b0;
        ilimCode[c*10 +: 10] <= 10'(dssp_pkg::ILIM_MAX_CODE);
        relayClosed[c] <= 1'b0;
        senseInternal[c] <= 1'b1;
        gateLed[c] <= dssp_pkg::LED_OFF;
      end else begin
        dacCode[c*16 +: 16] <= outCode;
        railHigh[c] <= (vProg >= CW'(dssp_pkg::RAIL_HIGH_CODE)); // [RULE6]
        ilimCode[c*10 +: 10] <= cfg_reg[c].ilim; // [RULE7]
        relayClosed[c] <= relayOn; // [RULE9]
        senseInternal[c] <= !cfg_reg[c].fourWire; // [RULE16]
        if (clFlag_reg[c] || cfg_reg[c].chanCal) gateLed[c] <= dssp_pkg::LED_RED; // [RULE8]
        else if (relayOn) gateLed[c] <= dssp_pkg::LED_GREEN; // [RULE15]
        else gateLed[c] <= dssp_pkg::LED_OFF;
      end
    end

    assign chHit[c] = inCh;
    assign chRead[c] = (regAddr[3:0] == dssp_pkg::OFS_VSET) ? 32'(vProg) :
      (regAddr[3:0] == dssp_pkg::OFS_ILIM) ? {22'h00_0000, cfg_reg[c].ilim} :
      (regAddr[3:0] == dssp_pkg::OFS_CONN) ? {29'h0000_0000, cfg_reg[c].chanCal,
                                              cfg_reg[c].fourWire, cfg_reg[c].relayClose} :
      {28'h000_0000, play_reg[c], relayOn, otFlag_reg[c], clFlag_reg[c]}; // [RULE11]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      monVoltPrev <= '0;
      monCurPrev <= '0;
    end else begin
      monVoltPrev <= mvSync_reg;
      monCurPrev <= miSync_reg;
    end
  end

  // ---------------- module level outputs ----------------
  wire mainRed = ctrl_reg[dssp_pkg::CTRL_SELFTEST] || ctrl_reg[dssp_pkg::CTRL_AUTOCAL] ||
                 ctrl_reg[dssp_pkg::CTRL_STERR];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      driverEnable <= 1'b0;
      mainLed <= dssp_pkg::LED_OFF;
    end else begin
      driverEnable <= !shutdown; // [RULE9]
      if (mainRed) mainLed <= dssp_pkg::LED_RED; // [RULE14]
      else if (measMode) mainLed <= dssp_pkg::LED_GREEN;
      else mainLed <= dssp_pkg::LED_OFF;
    end
  end

  // ---------------- read path ----------------
  wire [31:0] rdMux =
    (regAddr == dssp_pkg::OFS_CTRL) ? {28'h000_0000, ctrl_reg} :
    (regAddr == dssp_pkg::OFS_CLKDIV) ? {12'h000, clkDiv_reg} :
    (regAddr == dssp_pkg::OFS_MEMADDR) ? {19'h0_0000, memAddr_reg} :
    (regAddr == dssp_pkg::OFS_STIMSTART) ? stimStart_reg :
    (regAddr == dssp_pkg::OFS_STIMLAST) ? stimLast_reg :
    (regAddr == dssp_pkg::OFS_MON0) ? {monI_reg[15:0], monV_reg[15:0]} :
    (regAddr == dssp_pkg::OFS_MON1) ? {monI_reg[31:16], monV_reg[31:16]} :
    chHit[0] ? chRead[0] :
    chHit[1] ? chRead[1] : 32'h0000_0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) regRdata <= 32'h0000_0000;
    else regRdata <= regRd ? rdMux : 32'h0000_0000;
  end
endmodule // dssp_top
`default_nettype wire

// file: test/dssp_host_model.sv
// host controller model: register bus master and command sequences
`timescale 1ns/1ps
`default_nettype none
module dssp_host_model (
  input wire logic clk_sys,
  output logic [dssp_pkg::ADDR_W-1:0] regAddr,
  output logic [31:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [31:0] regRdata
);
  initial begin
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    // data is meaningless once the strobe drops, so it does not hold the old word
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  // mode first, then the channel's own trigger
  task automatic start_stim(input int ch);
    wr(dssp_pkg::OFS_CTRL, 32'h0000_0001);
    wr(dssp_pkg::OFS_TRIG, 32'(1 << ch));
  endtask
  task automatic clear_limiter(input int ch, input logic [31:0] want);
    logic [7:0] base;
    base = dssp_pkg::OFS_CH_BASE + 8'(ch) * dssp_pkg::OFS_CH_STRIDE;
    wr(base, 32'h0000_0000);
    wr(base + 8'h08, 32'h0000_0000);
    wr(base + 8'h04, 32'(dssp_pkg::ILIM_MIN_CODE));
    wr(base + 8'h04, want);
  endtask
endmodule // dssp_host_model
`default_nettype wire

// file: test/dssp_top_monitor.sv
// port-level checker of the dual supply control block
`timescale 1ns/1ps
`default_nettype none
module dssp_top_monitor #(
  parameter int NCH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [dssp_pkg::ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic thermalShutdownPin,
  input wire logic [NCH-1:0] currentLimitPin,
  input wire logic [NCH*10-1:0] ilimCode,
  input wire logic [NCH-1:0] relayClosed,
  input wire logic driverEnable,
  input wire dssp_pkg::dssp_led_t [NCH-1:0] gateLed
);
  default clocking mcb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rdata_idle;
    regRdata != 32'h0000_0000 |-> $past(regRd);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data out of slot");
  property p_trig_zero;
    $past(regRd) && $past(regAddr) == dssp_pkg::OFS_TRIG |-> regRdata == 32'h0000_0000;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger reads nonzero");
  property p_div_range;
    $past(regRd) && $past(regAddr) == dssp_pkg::OFS_CLKDIV
      |-> regRdata inside {[32'h0000_0001:32'h000F_4240]};
  endproperty
  a_div_range: assert property (p_div_range) else $error("divider out of range");
  property p_ilim_range;
    int'(ilimCode[9:0]) inside {[dssp_pkg::ILIM_MIN_CODE:dssp_pkg::ILIM_MAX_CODE]} &&
      int'(ilimCode[19:10]) inside {[dssp_pkg::ILIM_MIN_CODE:dssp_pkg::ILIM_MAX_CODE]};
  endproperty
  a_ilim_range: assert property (p_ilim_range) else $error("limit code out of range");
  property p_hot_off;
    thermalShutdownPin [*6] |-> relayClosed == '0 && !driverEnable;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("no shutdown when hot");
  property p_off_open;
    !driverEnable |-> relayClosed == '0;
  endproperty
  a_off_open: assert property (p_off_open) else $error("relay closed, driver off");
  property p_limit_red0;
    currentLimitPin[0] [*6] |-> gateLed[0] == dssp_pkg::LED_RED;
  endproperty
  a_limit_red0: assert property (p_limit_red0) else $error("ch0 led not red");
  property p_limit_red1;
    currentLimitPin[1] [*6] |-> gateLed[1] == dssp_pkg::LED_RED;
  endproperty
  a_limit_red1: assert property (p_limit_red1) else $error("ch1 led not red");
  property p_gate_lit;
    $rose(relayClosed[0]) |-> ##[0:2] gateLed[0] != dssp_pkg::LED_OFF;
  endproperty
  a_gate_lit: assert property (p_gate_lit) else $error("gate led dark");
endmodule // dssp_top_monitor
bind dssp_top dssp_top_monitor #(.NCH(NCH)) dssp_top_monitor_i (.clk_sys, .rst_n, .regAddr,
  .regRd, .regRdata, .thermalShutdownPin, .currentLimitPin, .ilimCode, .relayClosed,
  .driverEnable, .gateLed);
`default_nettype wire

// file: test/dssp_top_tb.sv
// self-checking bench of the dual supply control block
`timescale 1ns/1ps
`default_nettype none
module dssp_top_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, dacCode, d;
  logic regWr, regRd, driverEnable;
  logic thermalShutdownPin = 1'b0;
  logic [1:0] currentLimitPin = 2'b00;
  logic [31:0] monVoltPin = 32'h0000_0000;
  logic [31:0] monCurPin = 32'h0000_0000;
  logic [1:0] railHigh, relayClosed, senseInternal;
  logic [19:0] ilimCode;
  dssp_pkg::dssp_led_t mainLed;
  dssp_pkg::dssp_led_t [1:0] gateLed;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam logic [31:0] RED = 32'(dssp_pkg::LED_RED);
  localparam logic [31:0] GREEN = 32'(dssp_pkg::LED_GREEN);
  always #2.5 clk_sys = ~clk_sys;
  dssp_top #(.NCH(2)) dssp_top_i (.clk_sys, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .thermalShutdownPin, .currentLimitPin, .monVoltPin, .monCurPin, .dacCode,
    .railHigh, .ilimCode, .relayClosed, .senseInternal, .driverEnable, .mainLed, .gateLed);
  dssp_host_model dssp_host_model_i (.clk_sys, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    dssp_host_model_i.wr(a, v);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    dssp_host_model_i.rd(a, d);
    chk(what, d, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // bounded wait for the next played sample; returns its cycle stamp
  task automatic next_sample(inout logic [15:0] prev, output int at);
    int k;
    k = 0;
    while (dacCode[15:0] === prev && k < 300) begin
      tick(1);
      k++;
    end
    prev = dacCode[15:0];
    at = cycles;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    logic [15:0] prev;
    int t1, t2, t3, t4;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(2);
    chk("ilim0", 32'(ilimCode[9:0]), 32'(dssp_pkg::ILIM_MAX_CODE));
    chk("ilim1", 32'(ilimCode[19:10]), 32'(dssp_pkg::ILIM_MAX_CODE));
    chk("sense", 32'(senseInternal), 32'h0000_0003);
    chk("mainled", 32'(mainLed), 32'(dssp_pkg::LED_OFF));
    rdchk(dssp_pkg::OFS_CLKDIV, 32'h0000_0001, "clkdiv");
    wr(dssp_pkg::OFS_CLKDIV, 32'h000F_FFFF);
    rdchk(dssp_pkg::OFS_CLKDIV, 32'h000F_4240, "divmax");
    wr(dssp_pkg::OFS_CLKDIV, 32'h0000_0000);
    rdchk(dssp_pkg::OFS_CLKDIV, 32'h0000_0001, "divzero");
    rdchk(8'hFC, 32'h0000_0000, "unmapped");
    rdchk(dssp_pkg::OFS_TRIG, 32'h0000_0000, "trig");
    $display("reset test done");
    wr(8'h10, 32'(dssp_pkg::RAIL_HIGH_CODE));
    wr(8'h20, 32'(dssp_pkg::RAIL_HIGH_CODE - 1));
    tick(3);
    chk("rail", 32'(railHigh), 32'h0000_0001);
    chk("dac", dacCode,
      32'(dssp_pkg::RAIL_HIGH_CODE - 1) << 16 | 32'(dssp_pkg::RAIL_HIGH_CODE));
    wr(8'h10, 32'h0000_7FFF);
    rdchk(8'h10, 32'(dssp_pkg::VSET_MAX_CODE), "vmax");
    wr(8'h10, 32'hFFFF_8000);
    rdchk(8'h10, -32'(dssp_pkg::VSET_MAX_CODE), "vmin");
    $display("voltage test done");
    wr(8'h14, 32'h0000_000A);
    rdchk(8'h14, 32'(dssp_pkg::ILIM_MIN_CODE), "ilimlo");
    dssp_host_model_i.clear_limiter(0, 32'h0000_03E8);
    tick(3);
    chk("ilimhi", 32'(ilimCode[9:0]), 32'(dssp_pkg::ILIM_MAX_CODE));
    $display("limit setting test done");
    wr(8'h18, 32'h0000_0001);
    tick(3);
    chk("gate2w", 32'(gateLed[0]), GREEN);
    chk("sense2w", 32'(senseInternal[0]), 32'h0000_0001);
    wr(8'h18, 32'h0000_0003);
    tick(3);
    chk("gate4w", 32'(gateLed[0]), GREEN);
    chk("sense4w", 32'(senseInternal[0]), 32'h0000_0000);
    wr(8'h18, 32'h0000_0004);
    tick(3);
    chk("gatecal", 32'(gateLed[0]), RED);
    wr(8'h18, 32'h0000_0001);
    wr(8'h28, 32'h0000_0001);
    $display("connection test done");
    @(posedge clk_sys) currentLimitPin <= 2'b11;
    tick(7);
    chk("climled", 32'(gateLed), RED << 2 | RED);
    @(posedge clk_sys) currentLimitPin <= 2'b00;
    tick(6);
    rdchk(8'h1C, 32'h0000_0005, "climsticky");
    wr(8'h1C, 32'h0000_0001);
    wr(8'h2C, 32'h0000_0001);
    rdchk(8'h1C, 32'h0000_0004, "climclear");
    $display("current limit test done");
    monVoltPin <= 32'h1234_ABCD;
    monCurPin <= 32'h5678_0F0F;
    tick(8);
    rdchk(dssp_pkg::OFS_MON0, 32'h0F0F_ABCD, "mon0");
    rdchk(dssp_pkg::OFS_MON1, 32'h5678_1234, "mon1");
    $display("monitor test done");
    for (int i = 1; i < 4; i++) begin
      wr(dssp_pkg::OFS_CTRL, 32'(1 << i));
      tick(3);
      chk("mainred", 32'(mainLed), RED);
    end
    $display("led test done");
    wr(dssp_pkg::OFS_CTRL, 32'h0000_0000);
    wr(dssp_pkg::OFS_TRIG, 32'h0000_0001);
    rdchk(8'h1C, 32'h0000_0004, "noplay");
    wr(dssp_pkg::OFS_MEMADDR, 32'h0000_1FFD);
    wr(dssp_pkg::OFS_MEMDATA0, 32'h0000_1111);
    wr(dssp_pkg::OFS_MEMDATA0, 32'h0000_2222);
    wr(dssp_pkg::OFS_MEMDATA0, 32'h0000_3333);
    wr(dssp_pkg::OFS_STIMSTART, 32'h0000_1FFD);
    wr(8'h10, 32'h0000_0100);
    tick(3);
    prev = 16'h0100;
    dssp_host_model_i.start_stim(0);
    chk("meas", 32'(mainLed), GREEN);
    next_sample(prev, t1);
    chk("s0", 32'(prev), 32'h0000_1111);
    next_sample(prev, t2);
    chk("s1", 32'(prev), 32'h0000_2222);
    next_sample(prev, t3);
    chk("s2", 32'(prev), 32'h0000_3333);
    next_sample(prev, t4);
    chk("wrap", 32'(prev), 32'h0000_1111);
    chk("rate", 32'(t3 - t2), 32'(dssp_pkg::REF_DIV));
    chk("wraprate", 32'(t4 - t3), 32'(dssp_pkg::REF_DIV));
    rdchk(8'h1C, 32'h0000_000C, "play0");
    rdchk(8'h2C, 32'h0000_0004, "play1");
    wr(dssp_pkg::OFS_CTRL, 32'h0000_0000);
    tick(4);
    chk("stop", 32'(dacCode[15:0]), 32'h0000_0100);
    $display("stimulus test done");
    @(posedge clk_sys) thermalShutdownPin <= 1'b1;
    tick(8);
    chk("hotrelay", 32'(relayClosed), 32'h0000_0000);
    chk("hotdrv", 32'(driverEnable), 32'h0000_0000);
    rdchk(8'h2C, 32'h0000_0002, "hot1");
    wr(8'h1C, 32'h0000_0002);
    rdchk(8'h1C, 32'h0000_0002, "hotclr");
    @(posedge clk_sys) thermalShutdownPin <= 1'b0;
    tick(5);
    chk("cooldrv", 32'(driverEnable), 32'h0000_0000);
    wr(8'h1C, 32'h0000_0002);
    wr(8'h2C, 32'h0000_0002);
    tick(3);
    chk("recover", 32'(driverEnable), 32'h0000_0001);
    rdchk(8'h1C, 32'h0000_0004, "coolst");
    $display("thermal test done");
    end_sim();
  end
endmodule // dssp_top_tb
`default_nettype wire
